//--- design/flash_cfg.svh
// constants of the flash and torch sequencer
//
// Behaviour
// - thermistor below threshold powers everything down and sets overtemp flag
// - nrst input resets the block into power off, no power pin needed
// - trigger style bit 0 selects level flash, 1 selects edge flash
// - level mode drives flash while trigger or request high, bounded by timer
// - level request held too long ends at exactly the programmed duration
// - torch drive follows torch pin or torch request bit in both styles
// - edge mode starts flash on a rising trigger or request bit
// - flash timer starts on rising trigger or request bit
// - level mode ends flash at once on release, else at expiry
// - level mode resets the timer on a falling trigger or request
// - edge mode ends flash at expiry even with trigger still high
// - edge mode resets the timer by itself at expiry
// - torch drive ends at once when torch pin or bit falls
// - current settles within 1ms flash, 300us torch, 500us torch-to-flash
// - after fault, enables written 0 then 1 recover; registers reset
`ifndef FLASH_CFG_SVH
`define FLASH_CFG_SVH

`define CLK_PERIOD_NS 10
`define HOST_WAIT_MS 5
`define FLASH_SETTLE_US 1000
`define TORCH_SETTLE_US 300
`define T2F_SETTLE_US 500
`define FLASH_STEP_US 50

// register byte offsets
`define OFS_ENABLE 4'h0
`define OFS_CONFIG 4'h4
`define OFS_LIGHT 4'h8
`define OFS_STATUS 4'hc

// field positions
`define ENA_CH1_BIT 0
`define ENA_CH2_BIT 1
`define CFG_TIME_LSB 0
`define CFG_EDGE_BIT 4
`define CFG_THR_LSB 5
`define LIGHT_TORCH_BIT 0
`define LIGHT_FLASH_BIT 1
`define ST_OVERTEMP_BIT 0
`define ST_POWERED_BIT 1
`define ST_FLASH_BIT 2
`define ST_TORCH_BIT 3
`define ST_SETTLED_BIT 4

// reset values
`define ENABLE_RST 2'h0
`define CONFIG_RST 8'h0f
`define LIGHT_RST 2'h0

`endif

//--- design/flash_pkg.sv
// types of the flash and torch sequencer
package flash_pkg;
  typedef enum logic [1:0] {pwr_off, pwr_on, pwr_fault} power_t;
  typedef enum logic [1:0] {drv_off, drv_torch, drv_flash} drive_t;
endpackage : flash_pkg

//--- design/flash_timer_if.sv
// link between the sequencer and its flash duration timer
`timescale 1ns/100ps
`default_nettype none
interface flash_timer_if;
  logic start;
  logic clear;
  logic [3:0] duration;
  logic running;
  logic expired;
  modport ctrl (output start, output clear, output duration,
    input running, input expired);
  modport tmr (input start, input clear, input duration,
    output running, output expired);
endinterface : flash_timer_if
`default_nettype wire

//--- design/flash_timer.sv
// flash safety timer: (duration+1) steps of step_cycles clocks
`timescale 1ns/100ps
`default_nettype none
module flash_timer #(
  parameter int STEP_CYCLES = 5000
) (
  input wire logic clock,
  input wire logic nrst,
  flash_timer_if.tmr tif
);
  localparam int DW = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(STEP_CYCLES - 1);

  if (STEP_CYCLES < 1) begin : g_bad_step
    $error("flash_timer: STEP_CYCLES must be at least 1");
  end

  logic [DW-1:0] div_r;
  logic [3:0] step_r;
  logic run_r;
  logic tick;

  // ------------------------------------------------------------
  // step divider
  // ------------------------------------------------------------
  assign tick = run_r && (div_r == DIV_LAST);

  always_ff @(posedge clock)
  begin
    if (!nrst || tif.start || tif.clear || tick)
      div_r <= '0;
    else if (run_r)
      div_r <= div_r + DW'(1);
  end

  // ------------------------------------------------------------
  // step count and run state
  // ------------------------------------------------------------
  assign tif.expired = tick && (step_r == tif.duration);
  assign tif.running = run_r;

  always_ff @(posedge clock)
  begin
    if (!nrst || tif.clear)
    begin
      run_r <= 1'b0;
      step_r <= 4'h0;
    end
    else if (tif.start)
    begin
      run_r <= 1'b1;
      step_r <= 4'h0;
    end
    else if (tif.expired)
    begin
      run_r <= 1'b0;
      step_r <= 4'h0;
    end
    else if (tick)
      step_r <= step_r + 4'h1;
  end

  chk_expiry_stops_run:
    assert property (@(posedge clock) disable iff (!nrst)
      tif.expired && !tif.start |=> !run_r)
    else $error("timer still running after expiry");
endmodule : flash_timer
`default_nettype wire

//--- design/flash_torch_sequencer.sv
// flash and torch sequencer with avalon-mm register slave
//
// Local design decisions: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "flash_cfg.svh"
module flash_torch_sequencer
  import flash_pkg::*;
#(
  parameter int FLASH_STEP_CYCLES =
    `FLASH_STEP_US * 1000 / `CLK_PERIOD_NS,
  parameter int FLASH_SETTLE_CYCLES =
    `FLASH_SETTLE_US * 1000 / `CLK_PERIOD_NS,
  parameter int TORCH_SETTLE_CYCLES =
    `TORCH_SETTLE_US * 1000 / `CLK_PERIOD_NS,
  parameter int T2F_SETTLE_CYCLES =
    `T2F_SETTLE_US * 1000 / `CLK_PERIOD_NS
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic strobe_pin,
  input wire logic torch_pin,
  input wire logic thermistor_low,
  output logic [2:0] thermal_threshold_select,
  output logic channel_one_enable,
  output logic channel_two_enable,
  output logic flash_drive,
  output logic torch_drive,
  output logic lamp_settled
);
  localparam int SMAX = (FLASH_SETTLE_CYCLES > T2F_SETTLE_CYCLES) ?
    FLASH_SETTLE_CYCLES : T2F_SETTLE_CYCLES;
  localparam int SW = $clog2(SMAX + 1);

  if (FLASH_SETTLE_CYCLES < 1 || TORCH_SETTLE_CYCLES < 1 ||
      T2F_SETTLE_CYCLES < 1 || TORCH_SETTLE_CYCLES > SMAX) begin : g_bad
    $error("flash_torch_sequencer: settle counts out of range");
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // ------------------------------------------------------------
  // register bus slave, one wait state per access
  // ------------------------------------------------------------
  logic ack_r;
  logic wr_en;
  logic [1:0] enable_r;
  logic [7:0] config_r;
  logic [1:0] light_r;
  logic [31:0] readdata_r;
  logic overtemp_r;
  power_t power_r;
  drive_t drive_r;
  logic settled_r;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    hit = (a == o);
  endfunction : hit

  assign waitrequest = (read || write) && !ack_r;
  assign wr_en = write && ack_r && byteenable[0];
  assign readdata = readdata_r;

  always_ff @(posedge clock)
  begin
    if (!nrst)
      ack_r <= 1'b0;
    else
      ack_r <= (read || write) && !ack_r;
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      readdata_r <= 32'h0;
    else if (read && !ack_r)
    begin
      readdata_r <= 32'h0;
      if (hit(address, `OFS_ENABLE))
        readdata_r[1:0] <= enable_r;
      else if (hit(address, `OFS_CONFIG))
        readdata_r[7:0] <= config_r;
      else if (hit(address, `OFS_LIGHT))
        readdata_r[1:0] <= light_r;
      else if (hit(address, `OFS_STATUS))
      begin
        readdata_r[`ST_OVERTEMP_BIT] <= overtemp_r;
        readdata_r[`ST_POWERED_BIT] <= (power_r == pwr_on);
        readdata_r[`ST_FLASH_BIT] <= (drive_r == drv_flash);
        readdata_r[`ST_TORCH_BIT] <= (drive_r == drv_torch);
        readdata_r[`ST_SETTLED_BIT] <= settled_r;
      end
    end
  end

  // ------------------------------------------------------------
  // power state and fault
  // ------------------------------------------------------------
  logic ena_write;
  logic ena_zero;
  logic recover;

  assign ena_write = wr_en && hit(address, `OFS_ENABLE);
  assign ena_zero = (writedata[1:0] == 2'h0);
  assign recover = ena_write && ena_zero && (power_r == pwr_fault);

  always_ff @(posedge clock)
  begin
    if (!nrst)
      power_r <= pwr_off;
    else
      case (power_r)
        pwr_off:
          if (ena_write && !ena_zero)
            power_r <= pwr_on;
        pwr_on:
          if (thermistor_low)
            power_r <= pwr_fault;
          else if (ena_write && ena_zero)
            power_r <= pwr_off;
        pwr_fault:
          if (recover)
            power_r <= pwr_off;
        default:
          power_r <= pwr_off;
      endcase
  end

  always_ff @(posedge clock)
  begin
    if (!nrst || recover)
      overtemp_r <= 1'b0;
    else if (power_r == pwr_on && thermistor_low)
      overtemp_r <= 1'b1;
  end

  // ------------------------------------------------------------
  // software registers, reset again on recovery
  // ------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!nrst)
      enable_r <= `ENABLE_RST;
    else if (ena_write)
      enable_r <= writedata[1:0];
  end

  always_ff @(posedge clock)
  begin
    if (!nrst || recover)
    begin
      config_r <= `CONFIG_RST;
      light_r <= `LIGHT_RST;
    end
    else
    begin
      if (wr_en && hit(address, `OFS_CONFIG))
        config_r <= writedata[7:0];
      if (wr_en && hit(address, `OFS_LIGHT))
        light_r <= writedata[1:0];
    end
  end

  assign thermal_threshold_select = config_r[`CFG_THR_LSB +: 3];
  assign channel_one_enable = enable_r[`ENA_CH1_BIT] && power_r == pwr_on;
  assign channel_two_enable = enable_r[`ENA_CH2_BIT] && power_r == pwr_on;

  // ------------------------------------------------------------
  // request edges and flash timer
  // ------------------------------------------------------------
  logic edge_mode;
  logic pin_prev_r;
  logic bit_prev_r;
  logic flash_rise;
  logic flash_fall;
  logic flash_req;
  logic torch_req;
  logic flash_on_r;
  logic powered;
  flash_timer_if tif ();

  assign powered = (power_r == pwr_on) && !thermistor_low;
  assign edge_mode = config_r[`CFG_EDGE_BIT];
  assign flash_req = strobe_pin || light_r[`LIGHT_FLASH_BIT];
  assign torch_req = torch_pin || light_r[`LIGHT_TORCH_BIT];
  assign flash_rise = (strobe_pin && !pin_prev_r) ||
    (light_r[`LIGHT_FLASH_BIT] && !bit_prev_r);
  assign flash_fall = !flash_req && (pin_prev_r || bit_prev_r);

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      pin_prev_r <= 1'b0;
      bit_prev_r <= 1'b0;
    end
    else
    begin
      pin_prev_r <= strobe_pin;
      bit_prev_r <= light_r[`LIGHT_FLASH_BIT];
    end
  end

  // a second rising source while running does not restart the flash
  assign tif.start = powered && flash_rise && !flash_on_r;
  assign tif.clear = !powered ||
    (!edge_mode && flash_fall);
  assign tif.duration = config_r[`CFG_TIME_LSB +: 4];

  flash_timer #(
    .STEP_CYCLES(FLASH_STEP_CYCLES)
  ) u_timer (
    .clock(clock),
    .nrst(nrst),
    .tif(tif)
  );

  always_ff @(posedge clock)
  begin
    if (!nrst || !powered)
      flash_on_r <= 1'b0;
    else if (tif.start)
      flash_on_r <= 1'b1;
    else if (tif.expired)
      flash_on_r <= 1'b0;
    else if (!edge_mode && flash_fall)
      flash_on_r <= 1'b0;
  end

  // ------------------------------------------------------------
  // lamp drive and settle tracking
  // ------------------------------------------------------------
  drive_t drive_nxt;
  logic [SW-1:0] settle_r;

  always_comb
  begin
    drive_nxt = drv_off;
    if (powered && flash_on_r)
      drive_nxt = drv_flash;
    else if (powered && torch_req)
      drive_nxt = drv_torch;
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      drive_r <= drv_off;
    else
      drive_r <= drive_nxt;
  end

  assign flash_drive = (drive_r == drv_flash);
  assign torch_drive = (drive_r == drv_torch);

  always_ff @(posedge clock)
  begin
    if (!nrst || drive_nxt == drv_off)
      settle_r <= '0;
    else if (drive_nxt != drive_r)
    begin
      if (drive_nxt == drv_torch)
        settle_r <= SW'(TORCH_SETTLE_CYCLES - 1);
      else if (drive_r == drv_torch)
        settle_r <= SW'(T2F_SETTLE_CYCLES - 1);
      else
        settle_r <= SW'(FLASH_SETTLE_CYCLES - 1);
    end
    else if (settle_r != '0)
      settle_r <= settle_r - SW'(1);
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      settled_r <= 1'b0;
    else
      settled_r <= (drive_r != drv_off) && (drive_nxt == drive_r) &&
        (settle_r == '0);
  end

  assign lamp_settled = settled_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_fault_seen;
    power_r == pwr_on && thermistor_low;
  endsequence

  sequence s_lamp_dark;
    !flash_drive && !torch_drive && overtemp_r;
  endsequence

  chk_overtemp_dark: assert property (
    s_fault_seen |=> s_lamp_dark ##1 s_lamp_dark)
  else $error("overtemp did not darken the lamp");

  chk_fault_holds: assert property (
    power_r == pwr_fault && !recover |=> power_r == pwr_fault)
  else $error("fault state left without clearing enables");

  chk_recover_clears: assert property (
    recover |=> power_r == pwr_off && !overtemp_r &&
      config_r == `CONFIG_RST && light_r == `LIGHT_RST)
  else $error("recovery did not reset registers");

  chk_flash_starts: assert property (
    tif.start |=> flash_on_r && tif.running ##1 flash_drive)
  else $error("flash did not start on rising request");

  chk_level_release: assert property (
    !edge_mode && flash_on_r && flash_fall && !tif.start |=>
      !flash_on_r ##1 !flash_drive)
  else $error("level flash not cut on release");

  chk_edge_expiry: assert property (
    edge_mode && tif.expired && flash_req && !tif.start |=>
      !flash_on_r ##1 !flash_drive)
  else $error("edge flash outlived its timer");

  chk_torch_follow: assert property (
    powered && !flash_on_r && !torch_req |=> !torch_drive)
  else $error("torch drive without request");

  chk_flash_priority: assert property (
    powered && flash_on_r && torch_req |=> flash_drive && !torch_drive)
  else $error("torch overrode flash");

  chk_wait_one: assert property (
    (read || write) && !ack_r |=> !waitrequest)
  else $error("bus access not answered in one wait state");
endmodule : flash_torch_sequencer
`default_nettype wire

//--- bench/flash_host.sv
// host side model: trigger pins and the thermistor comparator level
`timescale 1ns/100ps
`default_nettype none
module flash_host (
  input wire logic clock,
  output logic strobe_pin,
  output logic torch_pin,
  output logic thermistor_low
);
  initial
  begin
    strobe_pin = 1'b0;
    torch_pin = 1'b0;
    thermistor_low = 1'b0;
  end
  // levels change just after an edge and hold until the next call
  task automatic pins(input logic s, input logic t, input logic h);
    @(posedge clock);
    strobe_pin <= s;
    torch_pin <= t;
    thermistor_low <= h;
  endtask : pins
endmodule : flash_host
`default_nettype wire

//--- bench/test_flash_torch_sequencer.sv
// self-checking bench of the flash and torch sequencer
`timescale 1ns/100ps
`default_nettype none
module test_flash_torch_sequencer;
  localparam int STEP = 4;
  logic clock, nrst, read, write, waitrequest;
  logic [3:0] address, byteenable, d;
  logic [31:0] writedata, readdata, q;
  logic strobe_pin, torch_pin, thermistor_low;
  logic [2:0] thr;
  logic ch1, ch2, flash_drive, torch_drive, lamp_settled;
  logic [16:0] lfsr_r;
  logic [7:0] c;
  int err_count, check_count, n, lo, mdl[3];

  flash_torch_sequencer #(.FLASH_STEP_CYCLES(STEP),
    .FLASH_SETTLE_CYCLES(20), .TORCH_SETTLE_CYCLES(6),
    .T2F_SETTLE_CYCLES(10)) i_dut (.clock(clock), .nrst(nrst),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .strobe_pin(strobe_pin), .torch_pin(torch_pin),
    .thermistor_low(thermistor_low), .thermal_threshold_select(thr),
    .channel_one_enable(ch1), .channel_two_enable(ch2),
    .flash_drive(flash_drive), .torch_drive(torch_drive),
    .lamp_settled(lamp_settled));
  flash_host i_host (.clock(clock), .strobe_pin(strobe_pin),
    .torch_pin(torch_pin), .thermistor_low(thermistor_low));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [16:0] lfsr_step(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr_step

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      err_count++;
    end
  endtask : check

  task automatic end_of_test();
    if (err_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask : tick

  // one avalon access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a,
    input logic [7:0] v);
    int w;
    w = 0;
    @(posedge clock);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= {24'h0, v};
    @(posedge clock);
    while (waitrequest !== 1'b0 && w < 50)
    begin
      @(posedge clock);
      w++;
    end
    if (w == 50)
      err_count++;
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    bus(1'b1, a, v);
    if (a < 4'hc && byteenable[0])
      mdl[a[3:2]] = v;
  endtask : wr

  task automatic rdchk(input logic [3:0] a, input int exp);
    bus(1'b0, a, 8'h00);
    check(q, exp);
  endtask : rdchk

  task automatic flash_len(output int k);
    int w;
    w = 0;
    k = 0;
    while (flash_drive !== 1'b1 && w < 100)
    begin
      @(posedge clock);
      w++;
    end
    while (flash_drive === 1'b1 && k < 500)
    begin
      @(posedge clock);
      k++;
    end
  endtask : flash_len

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    err_count = 0;
    check_count = 0;
    lfsr_r = 17'd92387;
    nrst = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0;
    byteenable = 4'hf;
    mdl = '{0, 8'h0f, 0};
    fork
      begin
        tick(20000);
        err_count++;
        end_of_test();
      end
    join_none
    tick(4);
    nrst <= 1'b1;
    tick(1);
    check({ch1, ch2, flash_drive, torch_drive}, 32'h0);
    for (int i = 0; i < 3; i++)
      rdchk(4'(i * 4), mdl[i]);
    rdchk(4'h6, 0);
    byteenable <= 4'h0;
    wr(4'h4, 8'h00);
    byteenable <= 4'hf;
    rdchk(4'h4, mdl[1]);
    i_host.pins(1'b1, 1'b1, 1'b0);
    tick(4);
    check({flash_drive, torch_drive}, 32'h0);
    i_host.pins(1'b0, 1'b0, 1'b0);
    wr(4'h0, 8'h01);
    tick(10);
    check({ch1, ch2}, 32'h2);
    for (int m = 0; m < 2; m++)
    begin
      lfsr_r = lfsr_step(lfsr_r);
      d = lfsr_r[3:0] | 4'h2;
      c = {lfsr_r[7:5], 1'(m), d};
      lo = (int'(d) + 1) * STEP;
      wr(4'h4, c);
      tick(1);
      check(thr, c[7:5]);
      if (m == 0)
      begin
        i_host.pins(1'b1, 1'b0, 1'b0);
        tick(5);
        check(flash_drive, 32'h1);
        i_host.pins(1'b0, 1'b0, 1'b0);
        tick(3);
        check(flash_drive, 32'h0);
        i_host.pins(1'b1, 1'b0, 1'b0);
        flash_len(n);
        check(n >= lo && n <= lo + 2, 32'h1);
        tick(4);
        check(flash_drive, 32'h0);
        i_host.pins(1'b0, 1'b0, 1'b0);
        wr(4'h8, 8'h02);
        tick(3);
        check(flash_drive, 32'h1);
        wr(4'h8, 8'h00);
        tick(3);
        check(flash_drive, 32'h0);
      end
      else
      begin
        i_host.pins(1'b1, 1'b0, 1'b0);
        flash_len(n);
        check(n >= lo && n <= lo + 2, 32'h1);
        tick(4);
        check(flash_drive, 32'h0);
        i_host.pins(1'b0, 1'b0, 1'b0);
        i_host.pins(1'b1, 1'b0, 1'b0);
        i_host.pins(1'b0, 1'b0, 1'b0);
        flash_len(n);
        check(n >= lo && n <= lo + 2, 32'h1);
        wr(4'h8, 8'h02);
        flash_len(n);
        check(n >= lo && n <= lo + 2, 32'h1);
        wr(4'h8, 8'h00);
      end
    end
    wr(4'h4, 8'h03);
    i_host.pins(1'b0, 1'b1, 1'b0);
    tick(3);
    check(torch_drive, 32'h1);
    tick(12);
    check(lamp_settled, 32'h1);
    i_host.pins(1'b1, 1'b1, 1'b0);
    tick(3);
    check({flash_drive, torch_drive}, 32'h2);
    check(lamp_settled, 32'h0);
    i_host.pins(1'b0, 1'b1, 1'b0);
    tick(3);
    check({flash_drive, torch_drive}, 32'h1);
    i_host.pins(1'b0, 1'b0, 1'b0);
    tick(3);
    check(torch_drive, 32'h0);
    wr(4'h8, 8'h01);
    tick(3);
    check(torch_drive, 32'h1);
    wr(4'h8, 8'h00);
    tick(3);
    check(torch_drive, 32'h0);
    i_host.pins(1'b0, 1'b1, 1'b1);
    tick(3);
    check({ch1, torch_drive}, 32'h0);
    bus(1'b0, 4'hc, 8'h00);
    check(q[0], 32'h1);
    i_host.pins(1'b0, 1'b1, 1'b0);
    tick(3);
    check(torch_drive, 32'h0);
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h03);
    mdl = '{3, 8'h0f, 0};
    tick(3);
    check({ch1, ch2, torch_drive}, 32'h7);
    rdchk(4'h4, mdl[1]);
    bus(1'b0, 4'hc, 8'h00);
    check(q[0], 32'h0);
    i_host.pins(1'b0, 1'b0, 1'b0);
    end_of_test();
  end
endmodule : test_flash_torch_sequencer
`default_nettype wire
